// file: rtl/sbt_pkg.sv
// Shared constants for the sixteen-bit timer with pulse train
package sbt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOW   = 8'h1c;
    localparam logic [7:0] IDX_HIGH  = 8'h1d;
    localparam logic [7:0] IDX_LOAD  = 8'h1e;
    localparam logic [7:0] IDX_MODE  = 8'h20;
    localparam logic [7:0] IDX_IEN   = 8'h21;
    localparam logic [7:0] IDX_IFLG  = 8'h22;
    localparam logic [7:0] IDX_PORTA = 8'h23;

    localparam logic [7:0] ADDR_LOW   = {IDX_LOW[5:0], 2'b00};
    localparam logic [7:0] ADDR_HIGH  = {IDX_HIGH[5:0], 2'b00};
    localparam logic [7:0] ADDR_LOAD  = {IDX_LOAD[5:0], 2'b00};
    localparam logic [7:0] ADDR_MODE  = {IDX_MODE[5:0], 2'b00};
    localparam logic [7:0] ADDR_IEN   = {IDX_IEN[5:0], 2'b00};
    localparam logic [7:0] ADDR_IFLG  = {IDX_IFLG[5:0], 2'b00};
    localparam logic [7:0] ADDR_PORTA = {IDX_PORTA[5:0], 2'b00};

    // Field positions
    localparam int unsigned MODE_LSB  = 2;
    localparam int unsigned UFLOW_BIT = 5;
    localparam int unsigned PIN_BIT   = 5;

    // Reset values
    localparam logic [7:0]  MODE_RST  = 8'h00;
    localparam logic [7:0]  IEN_RST   = 8'h00;
    localparam logic [7:0]  PORTA_RST = 8'hff;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] LATCH_RST = 16'h0000;

    // Mode pair coding
    localparam logic [1:0] MODE_INTERVAL = 2'b00;
    localparam logic [1:0] MODE_PULSE    = 2'b01;
    localparam logic [1:0] MODE_EVENT    = 2'b10;
    localparam logic [1:0] MODE_RETRIG   = 2'b11;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic {SBT_PHASE_LOW, SBT_PHASE_HIGH} sbt_phase_t;

endpackage

// file: rtl/sbt_pin_sync.sv
// Three-stage pin synchroniser with agreed rising-edge detect
`timescale 1ns/100ps
`default_nettype none
module sbt_pin_sync
(
    input  wire logic clk_i,   // Core clock
    input  wire logic rst_i,   // Synchronous reset
    input  wire logic pin_i,   // Asynchronous pin
    output logic      level_o, // Filtered level
    output logic      rise_o   // One-cycle rising pulse
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire  agree = (s2_q == s3_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                lvl_q <= s3_q;
        end
    end

    assign rise_o  = agree & s3_q & ~lvl_q;
    assign level_o = lvl_q;
endmodule
`default_nettype wire

// file: rtl/sbt_axil_port.sv
// AXI4-Lite slave front end producing register strobes
`timescale 1ns/100ps
`default_nettype none
module sbt_axil_port
(
    input  wire logic       clk_i,     // Core clock
    input  wire logic       rst_i,     // Synchronous reset
    input  wire logic [7:0] awaddr_i,  // Write address
    input  wire logic       awvalid_i, // Write address valid
    output logic            awready_o, // Write address ready
    input  wire logic [7:0] wdata_i,   // Write data low byte
    input  wire logic       wstrb_i,   // Low byte strobe
    input  wire logic       wvalid_i,  // Write data valid
    output logic            wready_o,  // Write data ready
    output logic [1:0]      bresp_o,   // Write response
    output logic            bvalid_o,  // Write response valid
    input  wire logic       bready_i,  // Write response ready
    input  wire logic [7:0] araddr_i,  // Read address
    input  wire logic       arvalid_i, // Read address valid
    output logic            arready_o, // Read address ready
    output logic [7:0]      rdata_o,   // Read data
    output logic [1:0]      rresp_o,   // Read response
    output logic            rvalid_o,  // Read data valid
    input  wire logic       rready_i,  // Read data ready
    output logic            wr_en_o,   // Write taken pulse
    input  wire logic       wr_err_i,  // Write address unmapped
    output logic            rd_en_o,   // Read taken pulse
    input  wire logic [7:0] rd_data_i, // Read data of decode
    input  wire logic       rd_err_i   // Read address unmapped
);
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic       rvalid_q;
    logic [1:0] rresp_q;
    logic [7:0] rdata_q;

    wire wr_take = awvalid_i & wvalid_i & ~bvalid_q;
    wire rd_take = arvalid_i & ~rvalid_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= sbt_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= sbt_pkg::RESP_OKAY;
            rdata_q  <= 8'h00;
        end
        else
        begin
            if (wr_take)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_err_i ? sbt_pkg::RESP_SLVERR : sbt_pkg::RESP_OKAY;
            end
            else if (bready_i)
                bvalid_q <= 1'b0;
            if (rd_take)
            begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_err_i ? sbt_pkg::RESP_SLVERR : sbt_pkg::RESP_OKAY;
                rdata_q  <= rd_data_i;
            end
            else if (rready_i)
                rvalid_q <= 1'b0;
        end
    end

    assign awready_o = wr_take;
    assign wready_o  = wr_take;
    assign arready_o = rd_take;
    assign wr_en_o   = wr_take & wstrb_i;
    assign rd_en_o   = rd_take;
    assign bvalid_o  = bvalid_q;
    assign bresp_o   = bresp_q;
    assign rvalid_o  = rvalid_q;
    assign rresp_o   = rresp_q;
    assign rdata_o   = rdata_q;
endmodule
`default_nettype wire

// file: rtl/sbt_timer.sv
// Sixteen-bit down-counter with reload latches and pulse train output
//
// Behaviour
// - One 16-bit down-counter, reload latch B, latch C used only in pulse mode.
// - Read high index gives upper count byte; both low indices give lower byte.
// - Reading the lower count byte at the first low index clears underflow flag.
// - Writes to high and first low index fill latch B halves, any time.
// - Load index write fills latch B upper half, then copies latch B into counter.
// - Decrement past zero reloads latch B, or latch C after a pulse low phase, and sets underflow flag bit five.
// - Underflow flag cleared by lower byte read, load write, or reset.
// - Mode control bits three and two select the four counter modes.
// - Coding: 00 interval, 01 pulse train, 10 event, 11 retriggerable.
// - Interval mode decrements each clock; event mode on each qualifying event.
// - Event mode decrements on rising pin edges; source holds each level two clocks or more.
// - Retriggerable mode reloads on load write, underflow, and pin rising edge.
// - Retriggerable mode flags underflow only if no edge restarted count first.
// - Pulse mode high byte write also copies whole latch B into latch C.
// - Load write in pulse mode loads counter from latch B, pin goes low.
// - Pulse underflow alternates: after low load C, pin high; else B, low.
// - Reset clears mode bits to interval mode and all enable bits.
// - Reset zeroes mode control, interrupt enable and interrupt flag registers.
// - Reset sets port latch ones, so shared pin rests high.
`timescale 1ns/100ps
`default_nettype none
module sbt_timer
(
    input  wire logic       CORE_CLK_I,      // Core clock
    input  wire logic       RESET_I,         // Synchronous reset, high
    input  wire logic [7:0] S_AXI_AWADDR_I,  // Write address
    input  wire logic       S_AXI_AWVALID_I, // Write address valid
    output logic            S_AXI_AWREADY_O, // Write address ready
    input  wire logic [31:0] S_AXI_WDATA_I,  // Write data
    input  wire logic [3:0] S_AXI_WSTRB_I,   // Write byte strobes
    input  wire logic       S_AXI_WVALID_I,  // Write data valid
    output logic            S_AXI_WREADY_O,  // Write data ready
    output logic [1:0]      S_AXI_BRESP_O,   // Write response
    output logic            S_AXI_BVALID_O,  // Write response valid
    input  wire logic       S_AXI_BREADY_I,  // Write response ready
    input  wire logic [7:0] S_AXI_ARADDR_I,  // Read address
    input  wire logic       S_AXI_ARVALID_I, // Read address valid
    output logic            S_AXI_ARREADY_O, // Read address ready
    output logic [31:0]     S_AXI_RDATA_O,   // Read data
    output logic [1:0]      S_AXI_RRESP_O,   // Read response
    output logic            S_AXI_RVALID_O,  // Read data valid
    input  wire logic       S_AXI_RREADY_I,  // Read data ready
    input  wire logic       PIN_I,           // Shared pin level in
    output logic            PIN_O,           // Shared pin level out
    output logic            PIN_OE_O,        // Shared pin drive enable
    output logic            IRQ_O            // Interrupt request, high
);
    // Bus side strobes
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic [7:0] rdata_byte;
    logic       wr_unmapped;
    logic       rd_unmapped;

    // Registers
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] latch_b_q;
    logic [15:0] latch_b_d;
    logic [15:0] latch_c_q;
    logic [15:0] latch_c_d;
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [7:0]  ien_q;
    logic [7:0]  porta_q;
    logic        uflow_flag_q;
    logic        uflow_flag_d;
    logic        pin_q;
    logic        pin_oe_q;
    sbt_pkg::sbt_phase_t phase_q;
    sbt_pkg::sbt_phase_t phase_d;

    // Pin edge detect
    logic pin_level;
    logic pin_rise;

    sbt_axil_port u_port
    (
        .clk_i     (CORE_CLK_I),
        .rst_i     (RESET_I),
        .awaddr_i  (S_AXI_AWADDR_I),
        .awvalid_i (S_AXI_AWVALID_I),
        .awready_o (S_AXI_AWREADY_O),
        .wdata_i   (S_AXI_WDATA_I[7:0]),
        .wstrb_i   (S_AXI_WSTRB_I[0]),
        .wvalid_i  (S_AXI_WVALID_I),
        .wready_o  (S_AXI_WREADY_O),
        .bresp_o   (S_AXI_BRESP_O),
        .bvalid_o  (S_AXI_BVALID_O),
        .bready_i  (S_AXI_BREADY_I),
        .araddr_i  (S_AXI_ARADDR_I),
        .arvalid_i (S_AXI_ARVALID_I),
        .arready_o (S_AXI_ARREADY_O),
        .rdata_o   (rdata_byte),
        .rresp_o   (S_AXI_RRESP_O),
        .rvalid_o  (S_AXI_RVALID_O),
        .rready_i  (S_AXI_RREADY_I),
        .wr_en_o   (wr_en),
        .wr_err_i  (wr_unmapped),
        .rd_en_o   (rd_en),
        .rd_data_i (rd_data),
        .rd_err_i  (rd_unmapped)
    );

    sbt_pin_sync u_sync
    (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RESET_I),
        .pin_i   (PIN_I),
        .level_o (pin_level),
        .rise_o  (pin_rise)
    );

    assign S_AXI_RDATA_O = {24'h000000, rdata_byte};

    // Address decode
    wire [7:0] wa = S_AXI_AWADDR_I;
    wire [7:0] ra = S_AXI_ARADDR_I;
    wire [7:0] wd = S_AXI_WDATA_I[7:0];

    wire wa_low   = (wa == sbt_pkg::ADDR_LOW);
    wire wa_high  = (wa == sbt_pkg::ADDR_HIGH);
    wire wa_load  = (wa == sbt_pkg::ADDR_LOAD);
    wire wa_mode  = (wa == sbt_pkg::ADDR_MODE);
    wire wa_ien   = (wa == sbt_pkg::ADDR_IEN);
    wire wa_iflg  = (wa == sbt_pkg::ADDR_IFLG);
    wire wa_porta = (wa == sbt_pkg::ADDR_PORTA);
    assign wr_unmapped = ~(wa_low | wa_high | wa_load | wa_mode | wa_ien | wa_iflg | wa_porta);

    wire ra_low   = (ra == sbt_pkg::ADDR_LOW);
    wire ra_high  = (ra == sbt_pkg::ADDR_HIGH);
    wire ra_load  = (ra == sbt_pkg::ADDR_LOAD);
    wire ra_mode  = (ra == sbt_pkg::ADDR_MODE);
    wire ra_ien   = (ra == sbt_pkg::ADDR_IEN);
    wire ra_iflg  = (ra == sbt_pkg::ADDR_IFLG);
    wire ra_porta = (ra == sbt_pkg::ADDR_PORTA);
    assign rd_unmapped = ~(ra_low | ra_high | ra_load | ra_mode | ra_ien | ra_iflg | ra_porta);

    // Write strobes, low byte lane only
    wire wr_go       = wr_en;
    wire wr_low      = wr_go & wa_low;
    wire wr_high     = wr_go & wa_high;
    wire wr_load     = wr_go & wa_load;
    wire wr_mode     = wr_go & wa_mode;
    wire wr_ien      = wr_go & wa_ien;
    wire wr_porta    = wr_go & wa_porta;
    wire rd_low_clr  = rd_en & ra_low;

    // Mode selection
    wire [1:0] mode     = mode_q[sbt_pkg::MODE_LSB +: 2];
    wire       m_pulse  = (mode == sbt_pkg::MODE_PULSE);
    wire       m_event  = (mode == sbt_pkg::MODE_EVENT);
    wire       m_retrig = (mode == sbt_pkg::MODE_RETRIG);

    // Count enable: every clock, or each pin rise in event mode
    wire dec_en  = m_event ? pin_rise : 1'b1;
    wire retrig  = m_retrig & pin_rise & ~wr_load;
    wire at_zero = (count_q == 16'h0000);
    // A restart in the same cycle beats the underflow
    wire uflow   = dec_en & at_zero & ~wr_load & ~retrig;

    // Read data mux
    wire [7:0] iflg_view = {2'b00, uflow_flag_q, 5'b00000};
    // Shared pin bit reads the filtered pin level
    wire [7:0] porta_view = {porta_q[7:6], pin_level, porta_q[4:0]};
    assign rd_data = (ra_high)            ? count_q[15:8] :
                     (ra_low | ra_load)   ? count_q[7:0]  :
                     (ra_mode)            ? mode_q        :
                     (ra_ien)             ? ien_q         :
                     (ra_iflg)            ? iflg_view     :
                     (ra_porta)           ? porta_view    :
                                            8'h00;

    // Latch update
    always_comb
    begin
        latch_b_d = latch_b_q;
        latch_c_d = latch_c_q;
        if (wr_low)
            latch_b_d[7:0] = wd;
        if (wr_high | wr_load)
            latch_b_d[15:8] = wd;
        if (wr_high & m_pulse)
            latch_c_d = {wd, latch_b_q[7:0]};
    end

    // Counter update
    always_comb
    begin
        count_d = count_q;
        if (wr_load)
            count_d = {wd, latch_b_q[7:0]};
        else if (retrig)
            count_d = latch_b_q;
        else if (uflow)
        begin
            if (m_pulse && phase_q == sbt_pkg::SBT_PHASE_LOW)
                count_d = latch_c_q;
            else
                count_d = latch_b_q;
        end
        else if (dec_en)
            count_d = count_q - 16'h0001;
    end

    // Pulse phase
    wire [1:0] new_mode   = wd[sbt_pkg::MODE_LSB +: 2];
    wire       enter_pulse = wr_mode & (new_mode == sbt_pkg::MODE_PULSE) & ~m_pulse;

    always_comb
    begin
        phase_d = phase_q;
        if (enter_pulse)
            phase_d = sbt_pkg::SBT_PHASE_HIGH;
        else if (m_pulse & wr_load)
            phase_d = sbt_pkg::SBT_PHASE_LOW;
        else if (m_pulse & uflow)
        begin
            if (phase_q == sbt_pkg::SBT_PHASE_LOW)
                phase_d = sbt_pkg::SBT_PHASE_HIGH;
            else
                phase_d = sbt_pkg::SBT_PHASE_LOW;
        end
    end

    // Flag: a set in the clearing cycle wins
    assign uflow_flag_d = uflow | (uflow_flag_q & ~(rd_low_clr | wr_load));
    assign mode_d       = wr_mode ? wd : mode_q;

    // Pin drive: pulse output, else port latch in interval mode
    wire [1:0] mode_nx   = mode_d[sbt_pkg::MODE_LSB +: 2];
    wire [7:0] porta_nx  = wr_porta ? wd : porta_q;
    wire       pulse_nx  = (mode_nx == sbt_pkg::MODE_PULSE);
    wire       drive_nx  = pulse_nx | (mode_nx == sbt_pkg::MODE_INTERVAL);
    wire       level_nx  = pulse_nx ? (phase_d == sbt_pkg::SBT_PHASE_HIGH)
                                    : porta_nx[sbt_pkg::PIN_BIT];

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            count_q   <= sbt_pkg::CNT_RST;
            latch_b_q <= sbt_pkg::LATCH_RST;
            latch_c_q <= sbt_pkg::LATCH_RST;
            phase_q   <= sbt_pkg::SBT_PHASE_HIGH;
        end
        else
        begin
            count_q   <= count_d;
            latch_b_q <= latch_b_d;
            latch_c_q <= latch_c_d;
            phase_q   <= phase_d;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            mode_q       <= sbt_pkg::MODE_RST;
            ien_q        <= sbt_pkg::IEN_RST;
            uflow_flag_q <= 1'b0;
        end
        else
        begin
            mode_q       <= mode_d;
            uflow_flag_q <= uflow_flag_d;
            if (wr_ien)
                ien_q <= wd;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            porta_q  <= sbt_pkg::PORTA_RST;
            pin_q    <= 1'b1;
            pin_oe_q <= 1'b1;
        end
        else
        begin
            porta_q  <= porta_nx;
            pin_q    <= level_nx;
            pin_oe_q <= drive_nx;
        end
    end

    assign PIN_O    = pin_q;
    assign PIN_OE_O = pin_oe_q;
    assign IRQ_O    = uflow_flag_q & ien_q[sbt_pkg::UFLOW_BIT];
endmodule
`default_nettype wire

// file: tb/sbt_timer_assertions.sv
// Bus, pin and interrupt checks for the timer block
`timescale 1ns/100ps
`default_nettype none
module sbt_timer_checker
(
    input wire logic        CORE_CLK_I,      // Clock
    input wire logic        RESET_I,         // Reset
    input wire logic [7:0]  S_AXI_AWADDR_I,  // Write address
    input wire logic        S_AXI_AWVALID_I, // Address valid
    input wire logic        S_AXI_AWREADY_O, // Address ready
    input wire logic [31:0] S_AXI_WDATA_I,   // Write data
    input wire logic [3:0]  S_AXI_WSTRB_I,   // Strobes
    input wire logic        S_AXI_WVALID_I,  // Data valid
    input wire logic        S_AXI_WREADY_O,  // Data ready
    input wire logic [1:0]  S_AXI_BRESP_O,   // Write response
    input wire logic        S_AXI_BVALID_O,  // Response valid
    input wire logic        S_AXI_BREADY_I,  // Response ready
    input wire logic        S_AXI_ARVALID_I, // Read valid
    input wire logic        S_AXI_ARREADY_O, // Read ready
    input wire logic [31:0] S_AXI_RDATA_O,   // Read data
    input wire logic        S_AXI_RVALID_O,  // Read data valid
    input wire logic        S_AXI_RREADY_I,  // Read data ready
    input wire logic        PIN_O,           // Pin out
    input wire logic        PIN_OE_O,        // Pin enable
    input wire logic        IRQ_O            // Interrupt
);
    wire logic wtake;
    wire logic mapped;
    assign wtake = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign mapped = S_AXI_AWADDR_I inside {sbt_pkg::ADDR_LOW, sbt_pkg::ADDR_HIGH,
        sbt_pkg::ADDR_LOAD, sbt_pkg::ADDR_MODE, sbt_pkg::ADDR_IEN, sbt_pkg::ADDR_IFLG,
        sbt_pkg::ADDR_PORTA};
    default clocking chk_clk @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RESET_I);

    wr_answer_a: assert property (wtake |=> S_AXI_BVALID_O)
        else $error("write response missing");
    rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read response missing");
    bvalid_drop_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response held too long");
    rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data changed while waiting");
    lane_zero_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    busy_refuse_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
        else $error("write taken during response");
    wr_unmapped_a: assert property (wtake && !mapped |=> S_AXI_BRESP_O == sbt_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    irq_mask_a: assert property (wtake && S_AXI_AWADDR_I == sbt_pkg::ADDR_IEN && S_AXI_WSTRB_I[0]
        && !S_AXI_WDATA_I[5] |=> !IRQ_O)
        else $error("interrupt not masked");
    reset_state_a: assert property ($fell(RESET_I) |-> PIN_O && PIN_OE_O && !IRQ_O)
        else $error("pin or interrupt wrong after reset");

    cover property (wtake && !mapped);
    cover property ($rose(IRQ_O));
    cover property ($fell(PIN_OE_O));
endmodule
bind sbt_timer sbt_timer_checker chk_i (.*);
`default_nettype wire

// file: tb/sbt_pin_model.sv
// Far-side pin source that makes rising edges while the block listens
`timescale 1ns/100ps
`default_nettype none
module sbt_pin_model
(
    input  wire logic       clk_i,   // Clock
    input  wire logic       start_i, // Start a train
    input  wire logic [7:0] edges_i, // Rising edges wanted
    input  wire logic [7:0] half_i,  // Half period less one
    input  wire logic       pin_i,   // Block pin out
    input  wire logic       oe_i,    // Block drives pin
    output logic            line_o,  // Resolved pin level
    output logic            busy_o   // Train running
);
    logic       drv_q = 1'b1;
    logic [7:0] left_q = 8'h00;
    logic [7:0] tick_q = 8'h00;
    // Block wins while it drives; source rests high
    assign line_o = oe_i ? pin_i : drv_q;
    assign busy_o = start_i || (left_q != 8'h00);
    always @(posedge clk_i)
    begin
        if (start_i)
        begin
            left_q <= edges_i;
            tick_q <= half_i;
        end
        else if (left_q != 8'h00)
        begin
            if (tick_q != 8'h00)
                tick_q <= tick_q - 8'h01;
            else
            begin
                // Half period of at least one cycle
                tick_q <= half_i;
                drv_q <= !drv_q;
                left_q <= drv_q ? left_q : left_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/sbt_timer_tb_top.sv
// Self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
module sbt_timer_tb_top;
    logic        clk = 1'b0;
    logic        rst;
    logic [7:0]  awaddr, araddr, rdv;
    logic        awvalid, wvalid, bready, arvalid, rready, start, busy;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, irq, line;
    logic [1:0]  bresp, rresp, rrv;
    logic [7:0]  edges, half;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    sbt_timer dut
    (
        .CORE_CLK_I      (clk),
        .RESET_I         (rst),
        .S_AXI_AWADDR_I  (awaddr),
        .S_AXI_AWVALID_I (awvalid),
        .S_AXI_AWREADY_O (awready),
        .S_AXI_WDATA_I   (wdata),
        .S_AXI_WSTRB_I   (wstrb),
        .S_AXI_WVALID_I  (wvalid),
        .S_AXI_WREADY_O  (wready),
        .S_AXI_BRESP_O   (bresp),
        .S_AXI_BVALID_O  (bvalid),
        .S_AXI_BREADY_I  (bready),
        .S_AXI_ARADDR_I  (araddr),
        .S_AXI_ARVALID_I (arvalid),
        .S_AXI_ARREADY_O (arready),
        .S_AXI_RDATA_O   (rdata),
        .S_AXI_RRESP_O   (rresp),
        .S_AXI_RVALID_O  (rvalid),
        .S_AXI_RREADY_I  (rready),
        .PIN_I           (line),
        .PIN_O           (pin_out),
        .PIN_OE_O        (pin_oe),
        .IRQ_O           (irq)
    );

    sbt_pin_model far
    (
        .clk_i   (clk),
        .start_i (start),
        .edges_i (edges),
        .half_i  (half),
        .pin_i   (pin_out),
        .oe_i    (pin_oe),
        .line_o  (line),
        .busy_o  (busy)
    );

    task automatic complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        begin
            n_checks++;
            if (s !== e)
            begin
                mismatches++;
                $display("BAD %0t got %h want %h", $time, s, e);
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = sbt_pkg::RESP_OKAY);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= {24'h000000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
            @(posedge clk);
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            do @(negedge clk); while (bvalid !== 1'b1);
            chk({30'h0, bresp}, {30'h0, r});
            @(posedge clk);
            bready <= 1'b0;
        end
    endtask

    // Ready raised late so the slave must hold its answer
    task automatic rd(input logic [7:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            do @(negedge clk); while (arready !== 1'b1);
            @(posedge clk);
            arvalid <= 1'b0;
            do @(negedge clk); while (rvalid !== 1'b1);
            rdv = rdata[7:0];
            rrv = rresp;
            @(posedge clk);
            rready <= 1'b1;
            @(posedge clk);
            rready <= 1'b0;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        begin
            rd(a);
            chk({24'h0, rdv}, {24'h0, e});
            chk({30'h0, rrv}, {30'h0, sbt_pkg::RESP_OKAY});
        end
    endtask

    task automatic train(input logic [7:0] n, input logic [7:0] h);
        begin
            @(posedge clk);
            edges <= n;
            half <= h;
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            do @(negedge clk); while (busy);
        end
    endtask

    // Length of the next run of one level on the pin
    task automatic span(input logic lvl, input int e);
        int n;
        begin
            n = 0;
            while (pin_out !== lvl)
                @(negedge clk);
            while (pin_out === lvl)
            begin
                n++;
                @(negedge clk);
            end
            chk(n, e);
        end
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            complete_run;
        end
    end

    initial
    begin
        rst = 1'b1;
        {awaddr, araddr, wdata, edges, half} = '0;
        {awvalid, wvalid, bready, arvalid, rready, start} = '0;
        wstrb = 4'h1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(sbt_pkg::ADDR_MODE, 8'h00);
        rdc(sbt_pkg::ADDR_IEN, 8'h00);
        rdc(sbt_pkg::ADDR_PORTA, 8'hff);
        rdc(sbt_pkg::ADDR_IFLG, 8'h20);
        rd(8'h90);
        chk({30'h0, rrv}, {30'h0, sbt_pkg::RESP_SLVERR});
        wr(8'h90, 8'h55, sbt_pkg::RESP_SLVERR);
        wr(sbt_pkg::ADDR_LOW, 8'h34);
        wr(sbt_pkg::ADDR_LOAD, 8'h12);
        rdc(sbt_pkg::ADDR_HIGH, 8'h12);
        rdc(sbt_pkg::ADDR_IFLG, 8'h00);
        // Interval mode, period 257 cycles
        wr(sbt_pkg::ADDR_IEN, 8'h20);
        wr(sbt_pkg::ADDR_LOW, 8'h00);
        wr(sbt_pkg::ADDR_LOAD, 8'h01);
        chk({31'h0, irq}, 32'h0);
        repeat (300) @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(sbt_pkg::ADDR_LOW);
        rdc(sbt_pkg::ADDR_IFLG, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(sbt_pkg::ADDR_IEN, 8'h00);
        // Event counter: five rises from 0x0010
        wr(sbt_pkg::ADDR_MODE, 8'h08);
        rdc(sbt_pkg::ADDR_MODE, 8'h08);
        wr(sbt_pkg::ADDR_LOW, 8'h10);
        wr(sbt_pkg::ADDR_LOAD, 8'h00);
        chk({31'h0, pin_oe}, 32'h0);
        train(8'd5, 8'd4);
        repeat (10) @(negedge clk);
        rdc(sbt_pkg::ADDR_LOAD, 8'h0b);
        rdc(sbt_pkg::ADDR_LOW, 8'h0b);
        // Retriggerable: edges every 22 cycles hold off a 49-cycle period
        wr(sbt_pkg::ADDR_MODE, 8'h0c);
        wr(sbt_pkg::ADDR_LOW, 8'h30);
        wr(sbt_pkg::ADDR_LOAD, 8'h00);
        train(8'd6, 8'd10);
        rdc(sbt_pkg::ADDR_IFLG, 8'h00);
        repeat (60) @(negedge clk);
        rdc(sbt_pkg::ADDR_IFLG, 8'h20);
        // Pulse train: high 4 cycles from latch C 3, low 7 cycles from latch B 6
        wr(sbt_pkg::ADDR_MODE, 8'h04);
        wr(sbt_pkg::ADDR_LOW, 8'h03);
        wr(sbt_pkg::ADDR_HIGH, 8'h00);
        wr(sbt_pkg::ADDR_LOW, 8'h06);
        wr(sbt_pkg::ADDR_LOAD, 8'h00);
        @(negedge clk);
        chk({31'h0, pin_out}, 32'h0);
        span(1'b1, 4);
        span(1'b0, 7);
        span(1'b1, 4);
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(sbt_pkg::ADDR_MODE, 8'h00);
        chk({30'h0, pin_out, pin_oe}, 32'h3);
        wr(sbt_pkg::ADDR_PORTA, 8'hdf);
        chk({31'h0, pin_out}, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
